// ===== verilog/ripc_bank.sv
// Configuration registers for reference input priority and source path.
// Assumes a single 100 MHz clock and an Avalon-MM master on the same clock.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "ripc_regs.svh"

module ripc_bank #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    output logic [3:0] third_input_priority_o,
    output logic third_input_candidate_o,
    output logic [3:0] third_input_rank_o,
    output ripc_pkg::ripc_path_t first_ttl_path_o,
    output logic [3:0] first_ttl_freq_code_o,
    output logic [1:0] activity_bucket_select_o,
    output logic [3:0] bucket_cfg_onehot_o
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [3:0] third_input_priority;
    logic [7:0] first_ttl_input_source_config;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [3:0] next_third_input_priority;
    logic [7:0] next_first_ttl_input_source_config;
    logic next_ack;
    logic [31:0] next_rdata;
    logic [1:0] next_resp;

    function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = addr[7:2];
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
        hit = (addr[1:0] == 2'h0) && (word_index(addr) == idx);
    endfunction

    wire logic req = (avs_read_i || avs_write_i) && !ack;
    wire logic hit_prio = hit(avs_address_i, `RIPC_IDX_PRIO);
    wire logic hit_cfg = hit(avs_address_i, `RIPC_IDX_SRC_CFG);
    // The cycle with ack high is the one in which the master sees waitrequest low
    logic wr_done;
    assign wr_done = avs_write_i && ack;

    // Every request is answered one edge later; waitrequest drops in the ack cycle.
    always_comb begin
        next_third_input_priority = third_input_priority;
        next_first_ttl_input_source_config = first_ttl_input_source_config;
        next_ack = req;
        next_rdata = 32'h0000_0000;
        next_resp = 2'h0;
        // A write lands only on the edge that completes it, never while it still waits
        if (wr_done && avs_byteenable_i[0]) begin
            if (hit_prio) begin
                // Upper nibble is not stored, so it drops writes
                next_third_input_priority = avs_writedata_i[`RIPC_PRIO_MSB:0];
            end
            if (hit_cfg) begin
                next_first_ttl_input_source_config = avs_writedata_i[7:0];
            end
        end
        if (req) begin
            if (hit_prio) begin
                next_rdata = {28'h0000000, third_input_priority};
            end else if (hit_cfg) begin
                next_rdata = {24'h000000, first_ttl_input_source_config};
            end else begin
                // Unmapped word: slave error, reads zero, write dropped
                next_resp = 2'h2;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            third_input_priority <= `RIPC_PRIO_RESET;
            first_ttl_input_source_config <= `RIPC_SRC_CFG_RESET;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
            resp <= 2'h0;
        end else begin
            third_input_priority <= next_third_input_priority;
            first_ttl_input_source_config <= next_first_ttl_input_source_config;
            ack <= next_ack;
            rdata <= next_rdata;
            resp <= next_resp;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
    assign avs_readdata_o = rdata;
    assign avs_response_o = resp;

    // ------------------------------------------------------------
    // Decoded controls toward selection, DPLL and monitors
    // ------------------------------------------------------------
    // Decoded values are flops loaded from the next field contents, so they move on
    // the same edge as the fields and a consumer never sees a decode glitch
    localparam logic [3:0] PRIO_RESET = `RIPC_PRIO_RESET;
    localparam logic [7:0] SRC_CFG_RESET = `RIPC_SRC_CFG_RESET;
    logic divn;
    logic fixed_prediv_to_8k;
    logic third_input_candidate;
    logic [3:0] third_input_rank;
    ripc_pkg::ripc_path_t first_ttl_path;
    logic [3:0] bucket_cfg_onehot;
    logic next_third_input_candidate;
    logic [3:0] next_third_input_rank;
    ripc_pkg::ripc_path_t next_first_ttl_path;
    logic [3:0] next_bucket_cfg_onehot;

    // Rank 15 is best; the selector picks the largest rank, so a lower number wins
    function automatic logic [3:0] rank_of(input logic [3:0] prio);
        if (prio == 4'h0) begin
            rank_of = 4'h0;
        end else begin
            rank_of = 4'hf - prio + 4'h1;
        end
    endfunction

    // The pre-divider select wins; the 8 kHz select only counts while it is clear
    function automatic ripc_pkg::ripc_path_t path_of(input logic [7:0] cfg);
        if (cfg[`RIPC_DIVN_BIT]) begin
            path_of = ripc_pkg::RIPC_PATH_PRODIV;
        end else if (cfg[`RIPC_FIXED_PREDIV_TO_8K_BIT]) begin
            path_of = ripc_pkg::RIPC_PATH_FIXED8K;
        end else begin
            path_of = ripc_pkg::RIPC_PATH_DIRECT;
        end
    endfunction

    // One enable per shared configuration; this input's monitor takes exactly one
    function automatic logic [3:0] onehot_of(input logic [1:0] sel);
        onehot_of = 4'h1 << sel;
    endfunction

    always_comb begin
        next_third_input_candidate = (next_third_input_priority != 4'h0);
        next_third_input_rank = rank_of(next_third_input_priority);
        next_first_ttl_path = path_of(next_first_ttl_input_source_config);
        next_bucket_cfg_onehot = onehot_of(
            next_first_ttl_input_source_config[`RIPC_BUCKET_MSB:`RIPC_BUCKET_LSB]);
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            third_input_candidate <= (PRIO_RESET != 4'h0);
            third_input_rank <= rank_of(PRIO_RESET);
            first_ttl_path <= path_of(SRC_CFG_RESET);
            bucket_cfg_onehot <= onehot_of(SRC_CFG_RESET[`RIPC_BUCKET_MSB:`RIPC_BUCKET_LSB]);
        end else begin
            third_input_candidate <= next_third_input_candidate;
            third_input_rank <= next_third_input_rank;
            first_ttl_path <= next_first_ttl_path;
            bucket_cfg_onehot <= next_bucket_cfg_onehot;
        end
    end

    assign divn = first_ttl_input_source_config[`RIPC_DIVN_BIT];
    assign fixed_prediv_to_8k = first_ttl_input_source_config[`RIPC_FIXED_PREDIV_TO_8K_BIT];
    assign third_input_priority_o = third_input_priority;
    assign third_input_candidate_o = third_input_candidate;
    assign third_input_rank_o = third_input_rank;
    assign first_ttl_path_o = first_ttl_path;
    // Frequency code is only stored here; nothing in this block decodes it
    assign first_ttl_freq_code_o = first_ttl_input_source_config[`RIPC_FREQ_MSB:0];
    assign activity_bucket_select_o =
        first_ttl_input_source_config[`RIPC_BUCKET_MSB:`RIPC_BUCKET_LSB];
    assign bucket_cfg_onehot_o = bucket_cfg_onehot;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    prio_write_lands_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && !avs_waitrequest_o && hit_prio && avs_byteenable_i[0])
        |=> third_input_priority_o == $past(avs_writedata_i[3:0]))
        else $error("priority write not stored");
    prio_read_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && !avs_waitrequest_o && hit_prio) |-> avs_readdata_o[31:4] == 28'h0)
        else $error("priority upper bits not zero");
    rank_order_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        third_input_candidate_o |-> third_input_rank_o + third_input_priority_o == 5'h10)
        else $error("rank not inverse of priority");
    zero_disables_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (third_input_priority_o == 4'h0) == !third_input_candidate_o)
        else $error("candidate flag wrong");
    prodiv_path_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        divn |-> first_ttl_path_o == ripc_pkg::RIPC_PATH_PRODIV)
        else $error("pre-divider path not taken");
    direct_path_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!divn && !fixed_prediv_to_8k) |-> first_ttl_path_o == ripc_pkg::RIPC_PATH_DIRECT)
        else $error("direct path not taken");
    fixed8k_path_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!divn && fixed_prediv_to_8k) |-> first_ttl_path_o == ripc_pkg::RIPC_PATH_FIXED8K)
        else $error("fixed 8k path not taken");
    bucket_pick_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        bucket_cfg_onehot_o[activity_bucket_select_o] && $onehot(bucket_cfg_onehot_o))
        else $error("bucket select not one-hot");
    bucket_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && !avs_waitrequest_o && hit_cfg && avs_byteenable_i[0])
        |=> activity_bucket_select_o == $past(avs_writedata_i[5:4]))
        else $error("bucket write not stored");
    one_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ($rose(avs_read_i) || $rose(avs_write_i)) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("answer not after one wait");
    idle_no_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest high while idle");

    // ------------------------------------------------------------
    // Bus refusals, read-back and idle levels
    // ------------------------------------------------------------
    // Either refusal leaves every field as it was
    write_dropped_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && !avs_waitrequest_o && !(avs_byteenable_i[0] && (hit_prio || hit_cfg)))
        |=> $stable(third_input_priority_o) && $stable(first_ttl_freq_code_o)
            && $stable(activity_bucket_select_o) && $stable(first_ttl_path_o))
        else $error("refused write changed a field");
    unmapped_err_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ((avs_read_i || avs_write_i) && !avs_waitrequest_o && !hit_prio && !hit_cfg)
        |-> avs_response_o == 2'h2)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ((avs_read_i || avs_write_i) && !avs_waitrequest_o && (hit_prio || hit_cfg))
        |-> avs_response_o == 2'h0)
        else $error("mapped access refused");
    prio_read_back_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && !avs_waitrequest_o && hit_prio)
        |-> avs_readdata_o[3:0] == third_input_priority_o)
        else $error("priority read-back wrong");
    cfg_read_back_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_read_i && !avs_waitrequest_o && hit_cfg)
        |-> avs_readdata_o == {24'h000000, first_ttl_input_source_config})
        else $error("source config read-back wrong");
    // Read data and response stand only in the cycle that completes a transfer
    data_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !ack |-> (avs_readdata_o == 32'h0000_0000) && (avs_response_o == 2'h0))
        else $error("read data left standing");

    // ------------------------------------------------------------
    // Field contents after reset and between writes
    // ------------------------------------------------------------
    reset_values_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> (third_input_priority_o == PRIO_RESET)
            && (first_ttl_input_source_config == SRC_CFG_RESET))
        else $error("fields not at reset values");
    prio_stable_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !(avs_write_i && !avs_waitrequest_o && hit_prio && avs_byteenable_i[0])
        |=> $stable(third_input_priority_o))
        else $error("priority changed without a write");
    cfg_stable_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !(avs_write_i && !avs_waitrequest_o && hit_cfg && avs_byteenable_i[0])
        |=> $stable(first_ttl_freq_code_o) && $stable(activity_bucket_select_o)
            && $stable(first_ttl_path_o))
        else $error("source config changed without a write");
    freq_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && !avs_waitrequest_o && hit_cfg && avs_byteenable_i[0])
        |=> first_ttl_freq_code_o == $past(avs_writedata_i[3:0]))
        else $error("frequency code write not stored");
    prodiv_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && !avs_waitrequest_o && hit_cfg && avs_byteenable_i[0])
        |=> (first_ttl_path_o == ripc_pkg::RIPC_PATH_PRODIV) == $past(avs_writedata_i[7]))
        else $error("pre-divider select not from written bit");
    fixed8k_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && !avs_waitrequest_o && hit_cfg && avs_byteenable_i[0])
        |=> (first_ttl_path_o == ripc_pkg::RIPC_PATH_FIXED8K) == ($past(avs_writedata_i[7:6]) == 2'h1))
        else $error("fixed 8k select not from written bits");
    cand_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (avs_write_i && !avs_waitrequest_o && hit_prio && avs_byteenable_i[0])
        |=> third_input_candidate_o == ($past(avs_writedata_i[3:0]) != 4'h0))
        else $error("candidate flag not from written priority");
    rank_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !third_input_candidate_o |-> third_input_rank_o == 4'h0)
        else $error("disabled input still ranked");
    // Any rise of the programmed number between two nonzero values must lower the rank
    rank_monotone_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (third_input_candidate_o && $past(third_input_candidate_o)
            && (third_input_priority_o > $past(third_input_priority_o)))
        |-> third_input_rank_o < $past(third_input_rank_o))
        else $error("higher number did not lower the rank");

    cov_prio_off_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(third_input_candidate_o));
    cov_prodiv_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        divn && fixed_prediv_to_8k);
    cov_fixed8k_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        first_ttl_path_o == ripc_pkg::RIPC_PATH_FIXED8K);
    cov_bucket3_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        activity_bucket_select_o == 2'h3);
    cov_slverr_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        avs_response_o == 2'h2);

endmodule // ripc_bank

// ===== verilog/ripc_regs.svh
// Register offsets, field positions and reset values of the reference input config bank.
// Assumes byte offsets are word indexes; bus byte address is four times the index.
`ifndef RIPC_REGS_SVH
`define RIPC_REGS_SVH

// ------------------------------------------------------------
// Register indexes
// ------------------------------------------------------------
`define RIPC_IDX_PRIO        6'h1c
`define RIPC_IDX_SRC_CFG     6'h22

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RIPC_PRIO_MSB        3
`define RIPC_FREQ_MSB        3
`define RIPC_BUCKET_LSB      4
`define RIPC_BUCKET_MSB      5
`define RIPC_FIXED_PREDIV_TO_8K_BIT      6
`define RIPC_DIVN_BIT        7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RIPC_PRIO_RESET      4'h4
`define RIPC_SRC_CFG_RESET   8'h00

`endif

// ===== verilog/ripc_pkg.sv
// Types shared by the reference input config bank.
// Assumes nothing beyond a SystemVerilog compiler.
package ripc_pkg;

    // ------------------------------------------------------------
    // Path of the first TTL reference toward DPLL and monitor
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RIPC_PATH_DIRECT = 2'b00,
        RIPC_PATH_FIXED8K = 2'b01,
        RIPC_PATH_PRODIV = 2'b10
    } ripc_path_t;

endpackage

// ===== bench/ripc_bank_tb.sv
// Self-checking bench for the reference input config bank.
// Assumes one 100 MHz clock and an Avalon-MM master modelled by the bench tasks.
`timescale 1ns/100ps
`include "ripc_regs.svh"

module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] PRIO_A = {`RIPC_IDX_PRIO, 2'b00};
    localparam logic [7:0] CFG_A = {`RIPC_IDX_SRC_CFG, 2'b00};
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [1:0] avs_response_o;
    logic [3:0] third_input_priority_o;
    logic third_input_candidate_o;
    logic [3:0] third_input_rank_o;
    ripc_pkg::ripc_path_t first_ttl_path_o;
    logic [3:0] first_ttl_freq_code_o;
    logic [1:0] activity_bucket_select_o;
    logic [3:0] bucket_cfg_onehot_o;
    int err_count = 0;
    int checks = 0;
    logic [3:0] prios [4] = '{4'h0, 4'h1, 4'hf, 4'h4};
    logic [7:0] cfgs [4] = '{8'h05, 8'h5a, 8'ha3, 8'hfc};
    ripc_bank dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
        .third_input_priority_o(third_input_priority_o),
        .third_input_candidate_o(third_input_candidate_o),
        .third_input_rank_o(third_input_rank_o), .first_ttl_path_o(first_ttl_path_o),
        .first_ttl_freq_code_o(first_ttl_freq_code_o),
        .activity_bucket_select_o(activity_bucket_select_o),
        .bucket_cfg_onehot_o(bucket_cfg_onehot_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g); cmp(e, g); endtask
    task automatic chk_rsp(input logic [1:0] e, input logic [1:0] g); cmp(e, g); endtask
    task automatic chk_out(input logic [31:0] e, input logic [31:0] g); cmp(e, g); endtask
    task automatic chk_wait(input logic [31:0] e, input logic [31:0] g); cmp(e, g); endtask

    // Request raised after an edge, held until the rising edge that samples waitrequest low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rsp,
                        output int waits);
        waits = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            waits++;
            @(posedge clk_i);
        end
        rd = avs_readdata_o;
        rsp = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                          input logic [1:0] ersp);
        logic [31:0] rd;
        logic [1:0] rsp;
        int waits;
        xfer(1'b1, a, d, be, rd, rsp, waits);
        chk_rsp(ersp, rsp);
        chk_wait(32'h1, waits);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] ersp);
        logic [31:0] rd;
        logic [1:0] rsp;
        int waits;
        xfer(1'b0, a, 32'h0, 4'h0, rd, rsp, waits);
        chk_rd(e, rd);
        chk_rsp(ersp, rsp);
        chk_wait(32'h1, waits);
    endtask
    task automatic check_outs(input logic [3:0] p, input logic [7:0] c);
        @(negedge clk_i);
        chk_out(32'h0, {31'h0, avs_waitrequest_o});
        chk_out({28'h0, p}, {28'h0, third_input_priority_o});
        chk_out({31'h0, p != 4'h0}, {31'h0, third_input_candidate_o});
        chk_out((p != 4'h0) ? 32'h10 - p : 32'h0, {28'h0, third_input_rank_o});
        chk_out(c[7] ? 32'h2 : {31'h0, c[6]}, {30'h0, first_ttl_path_o});
        chk_out({30'h0, c[5:4]}, {30'h0, activity_bucket_select_o});
        chk_out(32'h1 << c[5:4], {28'h0, bucket_cfg_onehot_o});
        chk_out({28'h0, c[3:0]}, {28'h0, first_ttl_freq_code_o});
    endtask
    task automatic test_done;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        check_outs(4'h4, 8'h00);
        rd_reg(PRIO_A, 32'h4, 2'h0);
        rd_reg(CFG_A, 32'h0, 2'h0);
        $display("test reset done");
        // Upper nibble written as 4'ha must never read back
        foreach (prios[i]) begin
            wr_reg(PRIO_A, {24'h0, 4'ha, prios[i]}, 4'h1, 2'h0);
            rd_reg(PRIO_A, {28'h0, prios[i]}, 2'h0);
            check_outs(prios[i], 8'h00);
        end
        $display("test priority done");
        foreach (cfgs[i]) begin
            wr_reg(CFG_A, {24'h0, cfgs[i]}, 4'h1, 2'h0);
            rd_reg(CFG_A, {24'h0, cfgs[i]}, 2'h0);
            check_outs(4'h4, cfgs[i]);
        end
        $display("test source config done");
        wr_reg(8'h74, 32'hff, 4'h1, 2'h2);
        rd_reg(8'h74, 32'h0, 2'h2);
        wr_reg(PRIO_A + 8'h1, 32'h9, 4'h1, 2'h2);
        wr_reg(PRIO_A, 32'h9, 4'h0, 2'h0);
        rd_reg(PRIO_A, 32'h4, 2'h0);
        check_outs(4'h4, 8'hfc);
        $display("test refusals done");
        test_done;
    end

    initial begin
        repeat (2000) @(posedge clk_i);
        err_count++;
        test_done;
    end
endmodule // testbench
